/* pkg/rxa_pkg.sv */
// package: register map, field positions, reset values and carrier types for the rx A irq block
package rxa_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_EN = 8'h07;
    localparam logic [7:0] IDX_STATUS = 8'h08;
    localparam logic [7:0] IDX_DATA_A = 8'h09;
    localparam logic [7:0] IDX_GAP_LEN = 8'h0A;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h0B;

    // field positions shared by enable, status and clear registers
    localparam int BIT_FULL = 0;
    localparam int BIT_EOF = 1;
    localparam int BIT_OVERRUN = 2;
    localparam int EVT_W = 3;

    // reset values
    localparam logic [2:0] RST_IRQ_EN = 3'h0;
    localparam logic [2:0] RST_STATUS = 3'h0;
    localparam logic [7:0] RST_DATA_A = 8'h00;
    localparam logic [7:0] RST_GAP_LEN = 8'h00;
    localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } rxa_apb_req_t;

    // channel A receiver strobes, all on the system clock
    typedef struct packed {
        logic bit_stb;
        logic bit_ok;
        logic load;
        logic [7:0] data;
    } rxa_rx_t;

    // end-of-frame detector state
    typedef struct packed {
        logic armed;
        logic [7:0] count;
        logic eof;
    } rxa_eof_state_t;

    // top level state
    typedef struct packed {
        logic [2:0] irq_en;
        logic [2:0] status;
        logic [7:0] data_a;
        logic [7:0] gap_len;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } rxa_state_t;

endpackage

/* logic/rxa_eof_detect.sv */
// end-of-frame detector: counts invalid bits after a valid reception
module rxa_eof_detect (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bit_stb,
    input wire logic i_bit_ok,
    input wire logic [7:0] i_gap_len,
    output logic o_eof
);

    rxa_pkg::rxa_eof_state_t s_q;
    rxa_pkg::rxa_eof_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.eof = 1'b0;
        if (i_bit_stb)
        begin
            if (i_bit_ok)
            begin
                // any valid bit restarts the gap count
                s_d.armed = 1'b1;
                s_d.count = 8'h00;
            end
            else if (s_q.armed)
            begin
                // count+1 invalid bits now exceeds the gap when count equals it
                if (s_q.count == i_gap_len)
                begin
                    s_d.eof = 1'b1;
                    s_d.armed = 1'b0;
                    s_d.count = 8'h00;
                end
                else
                begin
                    s_d.count = s_q.count + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_eof = s_q.eof;

endmodule // rxa_eof_detect

/* logic/rxa_irq_ctrl.sv */
// channel A receive interrupt controller with apb register access
module rxa_irq_ctrl (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire rxa_pkg::rxa_rx_t I_RX,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_IRQ
);

    rxa_pkg::rxa_state_t s_q;
    rxa_pkg::rxa_state_t s_d;
    rxa_pkg::rxa_apb_req_t req;
    logic eof_evt;
    logic access;
    logic commit;
    logic [7:0] idx;
    logic addr_ok;
    logic [2:0] set_bits;
    logic [2:0] clr_bits;

    // word index of a byte address from bits 9:2; offset and high bits are ignored here and rejected by is_mapped
    function automatic logic [7:0] word_index(input logic [31:0] addr);
        word_index = addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [31:0] addr, input logic wr);
        logic [7:0] i;
        i = addr[9:2];
        is_mapped = 1'b0;
        if (addr[1:0] == 2'b00 && addr[31:10] == 22'h00_0000)
        begin
            case (i)
                rxa_pkg::IDX_IRQ_EN: is_mapped = 1'b1;
                rxa_pkg::IDX_GAP_LEN: is_mapped = 1'b1;
                rxa_pkg::IDX_STATUS: is_mapped = !wr;
                rxa_pkg::IDX_DATA_A: is_mapped = !wr;
                rxa_pkg::IDX_IRQ_CLR: is_mapped = wr;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    function automatic logic [31:0] read_value(
        input logic [7:0] i,
        input rxa_pkg::rxa_state_t s
    );
        read_value = 32'h0000_0000;
        case (i)
            rxa_pkg::IDX_IRQ_EN: read_value = {29'h0000_0000, s.irq_en};
            rxa_pkg::IDX_STATUS: read_value = {29'h0000_0000, s.status};
            rxa_pkg::IDX_DATA_A: read_value = {24'h00_0000, s.data_a};
            rxa_pkg::IDX_GAP_LEN: read_value = {24'h00_0000, s.gap_len};
            default: read_value = 32'h0000_0000;
        endcase
    endfunction

    rxa_eof_detect u_eof (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_bit_stb(I_RX.bit_stb),
        .i_bit_ok(I_RX.bit_ok),
        .i_gap_len(s_q.gap_len),
        .o_eof(eof_evt)
    );

    always_comb
    begin
        req.psel = I_PSEL;
        req.penable = I_PENABLE;
        req.pwrite = I_PWRITE;
        req.paddr = I_PADDR;
        req.pwdata = I_PWDATA;
    end

    // two-edge access: first edge latches read data and raises pready, second completes
    assign access = req.psel && req.penable;
    assign commit = access && s_q.pready;
    assign idx = word_index(req.paddr);
    assign addr_ok = is_mapped(req.paddr, req.pwrite);

    always_comb
    begin
        set_bits = 3'h0;
        clr_bits = 3'h0;

        // hardware events
        if (I_RX.load)
        begin
            set_bits[rxa_pkg::BIT_FULL] = 1'b1;
            if (s_q.status[rxa_pkg::BIT_FULL])
            begin
                // previous byte still unread when the new one arrives
                set_bits[rxa_pkg::BIT_OVERRUN] = 1'b1;
            end
        end
        if (eof_evt)
        begin
            set_bits[rxa_pkg::BIT_EOF] = 1'b1;
        end

        // software clears, only at the completing edge
        if (commit && !s_q.pslverr)
        begin
            if (req.pwrite && idx == rxa_pkg::IDX_IRQ_CLR)
            begin
                clr_bits = req.pwdata[2:0];
            end
            else if (!req.pwrite && idx == rxa_pkg::IDX_STATUS)
            begin
                // only a request the host actually saw is acknowledged
                clr_bits[rxa_pkg::BIT_EOF] = s_q.prdata[rxa_pkg::BIT_EOF];
            end
            else if (!req.pwrite && idx == rxa_pkg::IDX_DATA_A)
            begin
                // reading the byte clears the full flag unless a new byte loads in the same cycle; data_a keeps its value
                clr_bits[rxa_pkg::BIT_FULL] = 1'b1;
            end
        end
    end

    always_comb
    begin
        s_d = s_q;

        // set wins over a clear landing in the same cycle
        s_d.status = (s_q.status & ~clr_bits) | set_bits;

        if (I_RX.load)
        begin
            s_d.data_a = I_RX.data;
        end

        if (access && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            s_d.pslverr = !addr_ok;
            if (!req.pwrite && addr_ok)
            begin
                s_d.prdata = read_value(idx, s_q);
            end
            else
            begin
                s_d.prdata = rxa_pkg::RST_PRDATA;
            end
        end
        else if (commit)
        begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            if (req.pwrite && !s_q.pslverr)
            begin
                case (idx)
                    rxa_pkg::IDX_IRQ_EN: s_d.irq_en = req.pwdata[2:0];
                    rxa_pkg::IDX_GAP_LEN: s_d.gap_len = req.pwdata[7:0];
                    default: s_d.irq_en = s_q.irq_en;
                endcase
            end
        end
        else
        begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end

        // level output follows the next-state flags so it tracks them without lag
        s_d.irq = |(s_d.status & s_d.irq_en);
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            s_q.irq_en <= rxa_pkg::RST_IRQ_EN;
            s_q.status <= rxa_pkg::RST_STATUS;
            s_q.data_a <= rxa_pkg::RST_DATA_A;
            s_q.gap_len <= rxa_pkg::RST_GAP_LEN;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= rxa_pkg::RST_PRDATA;
            s_q.irq <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign O_PRDATA = s_q.prdata;
    assign O_PREADY = s_q.pready;
    assign O_PSLVERR = s_q.pslverr;
    assign O_IRQ = s_q.irq;

endmodule // rxa_irq_ctrl

/* testbench/rxa_checker.sv */
// checker: apb timing and interrupt cause assertions for rxa_irq_ctrl
module rxa_checker (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire rxa_pkg::rxa_rx_t I_RX,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_IRQ
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);
    // shadow of the enable register, so interrupt checks know what is allowed
    logic [2:0] en_q;
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
            en_q <= 3'h0;
        else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                 && I_PADDR == {22'h0, rxa_pkg::IDX_IRQ_EN, 2'b00})
            en_q <= I_PWDATA[2:0];
    end
    AST_READY_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("no ready after one wait cycle");
    AST_READY_ONE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held too long");
    AST_READY_IDLE: assert property (!I_PSEL |=> !O_PREADY)
        else $error("ready without select");
    AST_ERR_ZERO: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0000_0000)
        else $error("error without ready or with data");
    AST_MISALIGN: assert property (I_PSEL && I_PENABLE && !O_PREADY && I_PADDR[1:0] != 2'b00
        |=> O_PSLVERR) else $error("misaligned access accepted");
    AST_IRQ_CAUSE: assert property ($rose(O_IRQ) |-> $past(I_RX.load)
        || $past(I_RX.bit_stb, 2) || $past(O_PREADY && I_PWRITE)) else $error("irq without cause");
    AST_IRQ_HOLD: assert property ($fell(O_IRQ) |-> $past(O_PREADY))
        else $error("irq dropped without host access");
    AST_FULL_IRQ: assert property (I_RX.load |=> !en_q[0] || O_IRQ)
        else $error("load did not raise irq");
    AST_EN_OFF: assert property (en_q == 3'h0 |-> !O_IRQ)
        else $error("irq while all disabled");
    cover property (O_PSLVERR);
    cover property ($rose(O_IRQ) && $past(I_RX.bit_stb, 2));
    cover property ($fell(O_IRQ));
endmodule // rxa_checker

bind rxa_irq_ctrl rxa_checker u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_RX(I_RX), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));

/* testbench/rxa_host.sv */
// host model: apb master that runs single transfers for the testbench
module rxa_host (
    input wire logic i_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    output rxa_pkg::rxa_apb_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_req = '0;
    // leading edge wait keeps two transfers from driving in one time step
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        o_req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge i_clk);
        o_req.penable <= 1'b1;
        @(posedge i_clk);
        // no cycle count is assumed here; the bench watchdog ends a hung wait
        while (i_pready !== 1'b1)
        begin
            @(posedge i_clk);
        end
        rd = i_prdata;
        err = i_pslverr;
        o_req <= '0;
    endtask
endmodule // rxa_host

/* testbench/testbench.sv */
// testbench: register and interrupt scenarios for rxa_irq_ctrl
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] EN = rxa_pkg::IDX_IRQ_EN;
    localparam logic [7:0] ST = rxa_pkg::IDX_STATUS;
    localparam logic [7:0] DA = rxa_pkg::IDX_DATA_A;
    localparam logic [7:0] GP = rxa_pkg::IDX_GAP_LEN;
    localparam logic [7:0] CL = rxa_pkg::IDX_IRQ_CLR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    rxa_pkg::rxa_apb_req_t req;
    rxa_pkg::rxa_rx_t rx = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int n_tests = 0;
    int st = 0;
    int en = 0;
    int dat = 0;
    int arm = 0;
    int cnt = 0;
    int g = 0;
    rxa_irq_ctrl u_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(req.psel),
        .I_PENABLE(req.penable), .I_PWRITE(req.pwrite), .I_PADDR(req.paddr),
        .I_PWDATA(req.pwdata), .I_RX(rx), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_IRQ(irq));
    rxa_host u_host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_req(req));
    initial
    begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // refused reads must return zero, so x is 0 there
    task automatic acc(input logic w, input logic [31:0] a, input int v, input int x, input logic e);
        u_host.xfer(w, a, 32'(v), rd, err);
        chk({31'h0, err}, {31'h0, e});
        if (!w)
            chk(rd, 32'(x));
    endtask
    task automatic rxev(input logic stb, input logic ok, input logic ld, input logic [7:0] d);
        @(posedge clk);
        rx <= '{stb, ok, ld, d};
        @(posedge clk);
        rx <= '0;
        st = ld ? (st | 1 | ((st & 1) << 2)) : st;
        dat = ld ? d : dat;
        arm = (stb && ok) ? 1 : arm;
        cnt = (stb && ok) ? 0 : cnt + int'(stb && arm == 1);
        if (cnt == g + 1)
        begin
            st |= 2;
            arm = 0;
            cnt = 0;
        end
    endtask
    task automatic ck_irq();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, (st & en) != 0});
    endtask
    task automatic summarize();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        failures++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'ha073_dba8));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        acc(0, ad(EN), 0, 0, 0);
        acc(0, ad(ST), 0, 0, 0);
        acc(0, ad(DA), 0, 0, 0);
        acc(0, ad(GP), 0, 0, 0);
        acc(0, 32'h0000_0030, 0, 0, 1);
        acc(0, ad(EN) + 1, 0, 0, 1);
        acc(1, ad(ST), 1, 0, 1);
        acc(0, ad(CL), 0, 0, 1);
        for (int e = 0; e < 8; e++)
        begin
            en = e;
            acc(1, ad(EN), e, 0, 0);
            rxev(0, 0, 1, 8'($urandom));
            rxev(0, 0, 1, 8'($urandom));
            ck_irq();
            acc(0, ad(ST), 0, st, 0);
            acc(0, ad(DA), 0, dat, 0);
            acc(1, ad(CL), 7, 0, 0);
            st = 0;
        end
        en = 2;
        acc(1, ad(EN), 2, 0, 0);
        for (int k = 0; k < 2; k++)
        begin
            g = k ? $urandom_range(4, 1) : 0;
            acc(1, ad(GP), g, 0, 0);
            rxev(1, 0, 0, 0);
            rxev(1, 1, 0, 0);
            repeat (g) rxev(1, 0, 0, 0);
            ck_irq();
            rxev(1, 0, 0, 0);
            ck_irq();
            acc(0, ad(ST), 0, st, 0);
            st &= ~2;
            ck_irq();
        end
        summarize();
    end
endmodule // testbench
